// ===== src/pis_pkg.sv
// Package for the shared PCI interrupt steering and trigger select block.
// Assumes a byte-wide configuration port with an 8-bit index.
package pis_pkg;

	localparam int          IRQ_COUNT    = 16;
	localparam int          LINE_COUNT   = 4;
	localparam int          SYNC_STAGES  = 3;

	// Configuration indices
	localparam logic [7:0]  ADDR_ROUTE_A = 8'h52;
	localparam logic [7:0]  ADDR_ROUTE_B = 8'h53;
	localparam logic [7:0]  ADDR_ROUTE_C = 8'h54;
	localparam logic [7:0]  ADDR_ROUTE_D = 8'h55;
	localparam logic [7:0]  ADDR_LOWER   = 8'h56;
	localparam logic [7:0]  ADDR_UPPER   = 8'h57;

	// Field positions
	localparam int          ROUTE_EN_BIT = 7;
	localparam int          REFRESH_BIT  = 0;

	// Implemented bits; the others ignore writes and read as zero
	localparam logic [7:0]  MASK_ROUTE   = 8'h8F;
	localparam logic [7:0]  MASK_LOWER   = 8'hF8;
	localparam logic [7:0]  MASK_UPPER   = 8'hDF;

	// Values after reset
	localparam logic [7:0]  RST_ROUTE    = 8'h00;
	localparam logic [7:0]  RST_LOWER    = 8'h00;
	localparam logic [7:0]  RST_UPPER    = 8'h00;
	localparam logic [7:0]  RST_RDATA    = 8'h00;

	// Request levels that may take a shared line
	localparam logic [15:0] IRQ_ALLOWED  = 16'hDEF8;

	typedef struct packed
	{
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} pis_bus_t;

endpackage

// ===== src/pis_top.sv
// Steering of four shared PCI interrupt lines onto legacy request inputs,
// with per-input trigger mode overrides and the refresh enable.
// Assumes the shared lines are active-low pins from outside the clock domain,
// and a configuration master that keeps to one-cycle strobes.
//
// The plain strobed port was decided locally.

module pis_top
(
	input  wire logic        REF_CLK_I,
	input  wire logic        RESET_N_I,
	input  wire logic [7:0]  ADDR_I,
	input  wire logic [7:0]  WR_DATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	input  wire logic [3:0]  SHARED_LINE_N_I,
	output logic      [7:0]  RD_DATA_O,
	output logic      [15:0] REQ_O,
	output logic      [15:0] LEVEL_MODE_O,
	output logic             REFRESH_EN_O
);

	function automatic logic code_valid(input logic [3:0] code);
		code_valid = pis_pkg::IRQ_ALLOWED[code];
	endfunction

	function automatic logic route_hit(input logic [7:0] addr);
		route_hit = (addr >= pis_pkg::ADDR_ROUTE_A) && (addr <= pis_pkg::ADDR_ROUTE_D);
	endfunction

	pis_pkg::pis_bus_t bus;

	logic [7:0]  route [pis_pkg::LINE_COUNT];
	logic [7:0]  next_route [pis_pkg::LINE_COUNT];
	logic [7:0]  lower_trigger_mode;
	logic [7:0]  next_lower_trigger_mode;
	logic [7:0]  upper_trigger_mode_refresh;
	logic [7:0]  next_upper_trigger_mode_refresh;
	logic [7:0]  next_rd_data;

	logic [3:0]  sync_1;
	logic [3:0]  sync_2;
	logic [3:0]  sync_3;
	logic [3:0]  line_active;
	logic [3:0]  next_line_active;

	logic [15:0] next_req;
	logic [15:0] next_level_mode;
	logic        next_refresh_en;

	assign bus = '{addr: ADDR_I, wdata: WR_DATA_I, wr: WR_I, rd: RD_I};

	// Register writes and read data
	always_comb
	begin
		logic [1:0] idx;
		idx = 2'(bus.addr - pis_pkg::ADDR_ROUTE_A);
		next_route                     = route;
		next_lower_trigger_mode        = lower_trigger_mode;
		next_upper_trigger_mode_refresh = upper_trigger_mode_refresh;
		next_rd_data                   = pis_pkg::RST_RDATA;
		if (bus.wr)
		begin
			if (route_hit(bus.addr))
			begin
				next_route[idx] = bus.wdata & pis_pkg::MASK_ROUTE;
			end
			if (bus.addr == pis_pkg::ADDR_LOWER)
			begin
				next_lower_trigger_mode = bus.wdata & pis_pkg::MASK_LOWER;
			end
			if (bus.addr == pis_pkg::ADDR_UPPER)
			begin
				next_upper_trigger_mode_refresh = bus.wdata & pis_pkg::MASK_UPPER;
			end
		end
		if (bus.rd)
		begin
			if (route_hit(bus.addr))
			begin
				next_rd_data = route[idx];
			end
			else if (bus.addr == pis_pkg::ADDR_LOWER)
			begin
				next_rd_data = lower_trigger_mode;
			end
			else if (bus.addr == pis_pkg::ADDR_UPPER)
			begin
				next_rd_data = upper_trigger_mode_refresh;
			end
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			for (int i = 0; i < pis_pkg::LINE_COUNT; i++)
			begin
				route[i] <= pis_pkg::RST_ROUTE;
			end
			lower_trigger_mode         <= pis_pkg::RST_LOWER;
			upper_trigger_mode_refresh <= pis_pkg::RST_UPPER;
			RD_DATA_O                  <= pis_pkg::RST_RDATA;
		end
		else
		begin
			route                      <= next_route;
			lower_trigger_mode         <= next_lower_trigger_mode;
			upper_trigger_mode_refresh <= next_upper_trigger_mode_refresh;
			RD_DATA_O                  <= next_rd_data;
		end
	end

	// Shared line synchroniser, a change counts once stages two and three agree
	always_comb
	begin
		next_line_active = line_active;
		for (int i = 0; i < pis_pkg::LINE_COUNT; i++)
		begin
			if (sync_2[i] == sync_3[i])
			begin
				next_line_active[i] = !sync_3[i];
			end
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			sync_1      <= 4'hF;
			sync_2      <= 4'hF;
			sync_3      <= 4'hF;
			line_active <= 4'h0;
		end
		else
		begin
			sync_1      <= SHARED_LINE_N_I;
			sync_2      <= sync_1;
			sync_3      <= sync_2;
			line_active <= next_line_active;
		end
	end

	// Routed requests and trigger mode outputs
	always_comb
	begin
		next_req = 16'h0000;
		for (int i = 0; i < pis_pkg::LINE_COUNT; i++)
		begin
			if (route[i][pis_pkg::ROUTE_EN_BIT] && line_active[i])
			begin
				if (code_valid(route[i][3:0]))
				begin
					next_req[route[i][3:0]] = 1'b1;
				end
			end
		end
		next_level_mode = {upper_trigger_mode_refresh[7:6], 1'b0, upper_trigger_mode_refresh[4:1], 1'b0,
			lower_trigger_mode[7:3], 3'h0};
		next_refresh_en = upper_trigger_mode_refresh[pis_pkg::REFRESH_BIT];
	end

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			REQ_O        <= 16'h0000;
			LEVEL_MODE_O <= 16'h0000;
			REFRESH_EN_O <= 1'b0;
		end
		else
		begin
			REQ_O        <= next_req;
			LEVEL_MODE_O <= next_level_mode;
			REFRESH_EN_O <= next_refresh_en;
		end
	end

	// Checks
	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (!RESET_N_I);

	logic fresh;

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			fresh <= 1'b1;
		end
		else
		begin
			fresh <= 1'b0;
		end
	end

	a_line_b_write: assert property (WR_I && ADDR_I == pis_pkg::ADDR_ROUTE_B |=>
		route[1] == ($past(WR_DATA_I) & pis_pkg::MASK_ROUTE))
		else $error("line B routing write lost");
	a_line_c_write: assert property (WR_I && ADDR_I == pis_pkg::ADDR_ROUTE_C ##1 RD_I &&
		ADDR_I == pis_pkg::ADDR_ROUTE_C |=> RD_DATA_O == ($past(WR_DATA_I, 2) & pis_pkg::MASK_ROUTE))
		else $error("line C routing read back wrong");
	a_line_d_write: assert property (WR_I && ADDR_I == pis_pkg::ADDR_ROUTE_D |=>
		route[3][3:0] == $past(WR_DATA_I[3:0]) && route[3][7] == $past(WR_DATA_I[7]))
		else $error("line D routing write lost");
	a_disabled_quiet: assert property (route[0][7] == 1'b0 && route[1][7] == 1'b0 &&
		route[2][7] == 1'b0 && route[3][7] == 1'b0 |=> REQ_O == 16'h0000)
		else $error("request raised with all lines disconnected");
	a_line_a_route: assert property (route[0][7] && line_active[0] && code_valid(route[0][3:0])
		|=> REQ_O[$past(route[0][3:0])])
		else $error("line A request not delivered");
	a_invalid_levels: assert property ((REQ_O & ~pis_pkg::IRQ_ALLOWED) == 16'h0000)
		else $error("request on a forbidden level");
	a_code_fourteen: assert property (route[2] == 8'h8E && line_active[2] |=> REQ_O[14])
		else $error("code 1110 does not reach input 14");
	a_reserved_read: assert property (RD_I && route_hit(ADDR_I) |=> RD_DATA_O[6:4] == 3'h0)
		else $error("reserved routing bits read nonzero");
	a_reset_clear: assert property (fresh |-> route[0] == 8'h00 && route[1] == 8'h00 &&
		route[2] == 8'h00 && route[3] == 8'h00 && lower_trigger_mode == 8'h00 && REQ_O == 16'h0000)
		else $error("registers not cleared by reset");
	a_lower_level: assert property (WR_I && ADDR_I == pis_pkg::ADDR_LOWER ##1 !WR_I |=>
		LEVEL_MODE_O[7:0] == {$past(WR_DATA_I[7:3], 2), 3'h0})
		else $error("lower trigger mode not applied");
	a_unused_bits: assert property (RD_I && (ADDR_I == pis_pkg::ADDR_LOWER || ADDR_I == pis_pkg::ADDR_UPPER)
		|=> ($past(ADDR_I) == pis_pkg::ADDR_LOWER && RD_DATA_O[2:0] == 3'h0)
		|| ($past(ADDR_I) == pis_pkg::ADDR_UPPER && RD_DATA_O[5] == 1'b0))
		else $error("reserved trigger bits read nonzero");
	a_upper_level: assert property (WR_I && ADDR_I == pis_pkg::ADDR_UPPER ##1 !WR_I |=>
		LEVEL_MODE_O[15:8] == {$past(WR_DATA_I[7:6], 2), 1'b0, $past(WR_DATA_I[4:1], 2), 1'b0})
		else $error("upper trigger mode not applied");
	a_refresh_gate: assert property (WR_I && ADDR_I == pis_pkg::ADDR_UPPER ##1 !WR_I |=>
		REFRESH_EN_O == $past(WR_DATA_I[0], 2))
		else $error("refresh enable does not follow its bit");

	// Routed requests, stored fields, read answers and the line filter
	a_line_b_route: assert property (route[1][7] && line_active[1] && code_valid(route[1][3:0])
		|=> REQ_O[$past(route[1][3:0])])
		else $error("line B request not delivered");
	a_line_c_route: assert property (route[2][7] && line_active[2] && code_valid(route[2][3:0])
		|=> REQ_O[$past(route[2][3:0])])
		else $error("line C request not delivered");
	a_line_d_route: assert property (route[3][7] && line_active[3] && code_valid(route[3][3:0])
		|=> REQ_O[$past(route[3][3:0])])
		else $error("line D request not delivered");
	a_code_fifteen: assert property (route[3] == 8'h8F && line_active[3] |=> REQ_O[15])
		else $error("code 1111 does not reach input 15");
	a_lines_idle: assert property (line_active == 4'h0 |=> REQ_O == 16'h0000)
		else $error("request raised with no shared line asserted");
	a_read_idle: assert property (!RD_I |=> RD_DATA_O == pis_pkg::RST_RDATA)
		else $error("read data outside the read answer cycle");
	a_unmapped_read: assert property (RD_I && !route_hit(ADDR_I) && ADDR_I != pis_pkg::ADDR_LOWER
		&& ADDR_I != pis_pkg::ADDR_UPPER |=> RD_DATA_O == pis_pkg::RST_RDATA)
		else $error("unmapped index read nonzero");
	a_unmapped_write: assert property (WR_I && !route_hit(ADDR_I) && ADDR_I != pis_pkg::ADDR_LOWER
		&& ADDR_I != pis_pkg::ADDR_UPPER |=> $stable(lower_trigger_mode) && $stable(upper_trigger_mode_refresh)
		&& $stable(route[0]) && $stable(route[1]) && $stable(route[2]) && $stable(route[3]))
		else $error("unmapped index write changed a register");
	a_read_lower: assert property (RD_I && ADDR_I == pis_pkg::ADDR_LOWER |=>
		RD_DATA_O == $past(lower_trigger_mode))
		else $error("lower trigger register read back wrong");
	a_read_upper: assert property (RD_I && ADDR_I == pis_pkg::ADDR_UPPER |=>
		RD_DATA_O == $past(upper_trigger_mode_refresh))
		else $error("upper trigger register read back wrong");
	a_route_reserved: assert property (((route[0] | route[1] | route[2] | route[3])
		& ~pis_pkg::MASK_ROUTE) == 8'h00)
		else $error("reserved routing bits stored");
	a_trigger_reserved: assert property ((lower_trigger_mode & ~pis_pkg::MASK_LOWER) == 8'h00
		&& (upper_trigger_mode_refresh & ~pis_pkg::MASK_UPPER) == 8'h00)
		else $error("reserved trigger bits stored");
	a_fixed_edge: assert property ((LEVEL_MODE_O & ~pis_pkg::IRQ_ALLOWED) == 16'h0000)
		else $error("level mode on an input without an override bit");
	a_sync_filter: assert property (((line_active ^ $past(line_active)) & ($past(sync_2) ^ $past(sync_3))) == 4'h0)
		else $error("shared line accepted before two stages agreed");
	a_lower_hold: assert property (!(WR_I && ADDR_I == pis_pkg::ADDR_LOWER)
		|=> $stable(lower_trigger_mode))
		else $error("lower trigger register changed without a write");
	a_upper_hold: assert property (!(WR_I && ADDR_I == pis_pkg::ADDR_UPPER)
		|=> $stable(upper_trigger_mode_refresh))
		else $error("upper trigger register changed without a write");
	a_route_hold: assert property (!(WR_I && route_hit(ADDR_I)) |=> $stable(route[0]) && $stable(route[1])
		&& $stable(route[2]) && $stable(route[3]))
		else $error("routing register changed without a write");

	c_line_routed: cover property (route[0][7] && line_active[0] ##1 REQ_O != 16'h0000);
	c_level_set: cover property (LEVEL_MODE_O[15] && LEVEL_MODE_O[3]);
	c_refresh_on: cover property ($rose(REFRESH_EN_O));
	c_read_back: cover property (RD_I && ADDR_I == pis_pkg::ADDR_ROUTE_A ##1 RD_DATA_O[7]);
	c_write_read: cover property (WR_I && ADDR_I == pis_pkg::ADDR_ROUTE_C ##1 RD_I);

endmodule

// ===== tb/pis_legacy_model.sv
// Model of the cascaded legacy controller pair taking the routed requests.
// Assumes requests and trigger modes arrive registered on the same clock.
module pis_legacy_model
(
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic [15:0] req_i,
	input  wire logic [15:0] level_mode_i,
	output logic      [15:0] pending_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] last_req;
	logic [15:0] edge_seen;
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			last_req  <= 16'h0000;
			edge_seen <= 16'h0000;
		end
		else
		begin
			last_req  <= req_i;
			edge_seen <= edge_seen | (req_i & ~last_req);
		end
	end
	// Level inputs follow the request, edge inputs keep what they caught
	assign pending_o = (level_mode_i & req_i) | (~level_mode_i & edge_seen);
endmodule

// ===== tb/pci_irq_steering_and_trigger_select_tb.sv
// Self-checking bench for the shared line steering and trigger select block.
// Assumes the legacy controller model beside it and a 10 MHz clock.
module pci_irq_steering_and_trigger_select_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk;
	logic        rst_n;
	logic [7:0]  addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic [3:0]  line_n;
	logic [7:0]  rdata;
	logic [15:0] req;
	logic [15:0] level;
	logic        refresh;
	logic [15:0] pending;
	logic [7:0]  rv [6];
	int          errors;
	int          samples_checked;
	int          k;

	pis_top dut (.REF_CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WR_DATA_I(wdata), .WR_I(wr), .RD_I(rd),
		.SHARED_LINE_N_I(line_n), .RD_DATA_O(rdata), .REQ_O(req), .LEVEL_MODE_O(level), .REFRESH_EN_O(refresh));
	pis_legacy_model model (.clk_i(clk), .reset_n_i(rst_n), .req_i(req), .level_mode_i(level), .pending_o(pending));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	function automatic logic [7:0] reg_mask(int j);
		return (j < 4) ? pis_pkg::MASK_ROUTE : (j == 4) ? pis_pkg::MASK_LOWER : pis_pkg::MASK_UPPER;
	endfunction

	function automatic logic [15:0] exp_req();
		logic [15:0] e;
		e = 16'h0000;
		for (int i = 0; i < 4; i++)
			if (!line_n[i] && rv[i][7])
				e[rv[i][3:0]] = 1'b1;
		return e & pis_pkg::IRQ_ALLOWED;
	endfunction

	function automatic logic [15:0] exp_level();
		return {rv[5][7:6], 1'b0, rv[5][4:1], 1'b0, rv[4][7:3], 3'b000};
	endfunction

	task automatic complete_run();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] expected);
		samples_checked++;
		if (seen !== expected)
		begin
			errors++;
			$display("BAD t=%0t seen=%h expected=%h", $time, seen, expected);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask

	task automatic rd_check(input logic [7:0] a, input logic [7:0] expected);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		check({8'h00, rdata}, {8'h00, expected});
	endtask

	task automatic wr_rd_check(input logic [7:0] a, input logic [7:0] d, input logic [7:0] expected);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		rd    <= 1'b1;
		@(posedge clk);
		rd    <= 1'b0;
		#1;
		check({8'h00, rdata}, {8'h00, expected});
	endtask

	task automatic apply(input logic [3:0] pins);
		for (int j = 0; j < 6; j++)
			wr_reg(8'h52 + j[7:0], rv[j]);
		@(posedge clk);
		line_n <= pins;
		repeat (8) @(posedge clk);
		#1;
		check(req, exp_req());
		check(level, exp_level());
		check({15'h0000, refresh}, {15'h0000, rv[5][0]});
		check(pending & level, exp_req() & exp_level());
		check(pending & ~exp_level() & exp_req(), exp_req() & ~exp_level());
		for (int j = 0; j < 6; j++)
			rd_check(8'h52 + j[7:0], rv[j] & reg_mask(j));
	endtask

	task automatic do_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		check(level, 16'h0000);
		check({15'h0000, refresh}, 16'h0000);
		check(req, 16'h0000);
		foreach (rv[j])
			rv[j] = 8'h00;
		for (int j = 0; j < 6; j++)
			rd_check(8'h52 + j[7:0], 8'h00);
	endtask

	initial
	begin
		repeat (90000) @(posedge clk);
		errors++;
		complete_run();
	end

	initial
	begin
		rst_n = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		line_n = 4'hF;
		errors = 0;
		samples_checked = 0;
		void'($urandom(70886));
		do_reset();
		wr_reg(8'h60, 8'hFF);
		rd_check(8'h60, 8'h00);
		// Write then read with no idle cycle between the strobes
		for (k = 0; k < 6; k++)
		begin
			rv[k] = 8'($urandom);
			wr_rd_check(8'h52 + k[7:0], rv[k], rv[k] & reg_mask(k));
		end
		// Every code on every line, reserved bits written as ones
		for (k = 0; k < 64; k++)
		begin
			foreach (rv[j])
				rv[j] = 8'h00;
			rv[k % 4] = {4'hF, k[5:2]};
			rv[4] = 8'hFF;
			rv[5] = 8'($urandom);
			apply(~(4'h1 << (k % 4)));
		end
		// Random routes, modes and line levels, shared targets ORed
		for (k = 0; k < 40; k++)
		begin
			foreach (rv[j])
				rv[j] = 8'($urandom);
			apply(4'($urandom));
		end
		// Reset in mid-run with every line asserted
		@(posedge clk);
		line_n <= 4'h0;
		do_reset();
		repeat (8) @(posedge clk);
		#1;
		check(req, 16'h0000);
		complete_run();
	end
endmodule
